// ---- core/sic_pkg.sv ----
package sic_pkg;
    // register indices (printed offsets are not all multiples of four: byte address is index x4)
    localparam logic [7:0] SIC_IDX_FLAGS = 8'h16;
    localparam logic [7:0] SIC_IDX_ENABLES = 8'h17;
    localparam logic [7:0] SIC_IDX_OPCTRL = 8'h50;
    localparam logic [7:0] SIC_IDX_B1_UPSTREAM_OVERRIDE_BYTE = 8'h51;
    localparam logic [7:0] SIC_IDX_S_STATUS = 8'h60;
    localparam logic [7:0] SIC_IDX_B1_CTRL = 8'h61;
    localparam int SIC_AW = 10;
    // flag positions
    localparam int SIC_BIT_SRDY = 0;
    localparam int SIC_BIT_QNIB = 1;
    localparam int SIC_BIT_FRAME_SYNC_ERROR_LIVE = 2;
    localparam int SIC_BIT_ACT = 3;
    localparam int SIC_NFLAGS = 4;
    // operation control positions
    localparam int SIC_OP_STRICT = 7;
    localparam int SIC_OP_BSW = 6;
    localparam int SIC_OP_ROLE = 3;
    localparam logic [7:0] SIC_OP_MASK = 8'hC8;
    // s status positions
    localparam int SIC_ST_FRAME_SYNC_ERROR_LIVE = 5;
    localparam int SIC_ST_INFO3 = 4;
    localparam int SIC_ST_INFO1 = 3;
    // b1 control positions
    localparam int SIC_B1_FORCE = 0;
    localparam int SIC_B1_OVERRIDE_SELECT = 1;
    localparam int SIC_B1_LOOP = 2;
    localparam logic [7:0] SIC_RST_BYTE = 8'h00;
    localparam logic [1:0] SIC_HTRANS_NONSEQ = 2'h2;
endpackage

// ---- core/sic_ev_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sic_ev_if;
    logic [3:0] raw_set;
    logic rd_clear;
    logic [3:0] flags;
    modport owner (input raw_set, input rd_clear, output flags);
    modport user (output raw_set, output rd_clear, input flags);
endinterface
`default_nettype wire

// ---- core/sic_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none
module sic_sync3 (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // pin side
    input wire logic pin_in,
    // synchronised level
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts only when stages two and three agree
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule // sic_sync3
`default_nettype wire

// ---- core/sic_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module sic_flags
    import sic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // event port
    sic_ev_if.owner ev
);
    logic [SIC_NFLAGS-1:0] flags_q;
    logic [SIC_NFLAGS-1:0] flags_d;
    // set beats the read-clear so no event is lost
    assign flags_d = (ev.rd_clear ? '0 : flags_q) | ev.raw_set;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign ev.flags = flags_q;

    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!ev.rd_clear && (|flags_q)) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("flag dropped without read");
    a_read_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ev.rd_clear && ev.raw_set == '0) |=> (flags_q == '0))
        else $error("read did not clear flags");
endmodule // sic_flags
`default_nettype wire

// ---- core/sic_top.sv ----
// Behaviour
// - Each event flag sets on its condition, holds until the flag register is read, then clears.
// - Activation-change flag bit 3 sets when info 3, info 1 or the 3-bit state field change.
// - Frame-sync-error flag bit 2 sets only on a rising edge of the live error.
// - The live frame-sync error level is always readable in the s status register.
// - Q flag bit 1 sets when a full Q nibble lands in the receive multiframe register.
// - S-ready flag bit 0 sets when the current S nibbles have been sent.
// - The enable register holds one enable per flag in bits 3..0, reset to 0.
// - Control bit 7 low holds the indicator high from info 1 low to info 3 high; high keeps it low.
// - Control bit 6 low enables backswing suppression, high disables it; 0 is advised.
// - Control bit 3 selects the role: 0 network termination (reset), 1 line termination.
// - In line-termination role pin 2.6 is forced to input for the 8 kHz timing reference.
// - With force and select set and loopback clear, the override byte goes out on upstream B1.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sic_top
    import sic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // s-interface status from the line block
    input wire logic rx_activation_signal_3,
    input wire logic rx_activation_signal_1,
    input wire logic [2:0] activation_state_field,
    input wire logic frame_sync_error_live,
    input wire logic q_nibble_done,
    input wire logic s_nibbles_sent,
    // interrupt
    output logic s_irq,
    // operation control outputs
    output logic upstream_activation_indicator,
    output logic backswing_suppress_en,
    output logic termination_role_select,
    // port pin 2.6 direction
    input wire logic port2_dir6,
    output logic port2_pin6_oe,
    output logic timing_reference_8khz_sel,
    // b1 upstream path
    input wire logic [7:0] b1_upstream_normal,
    output logic [7:0] b1_upstream_out
);
    // info 3, info 1, frame error and state field pass a three-stage synchroniser; the Q and S pulses do not
    logic info3_s;
    logic info1_s;
    logic frame_sync_error_live_s;
    logic [2:0] asi_s;
    logic [5:0] pins_raw;
    logic [5:0] pins_s;
    assign pins_raw = {rx_activation_signal_3, rx_activation_signal_1,
                       frame_sync_error_live, activation_state_field};
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            sic_sync3 u_sync (
                .sys_clk(sys_clk),
                .sys_rst(sys_rst),
                .pin_in(pins_raw[gi]),
                .level_q(pins_s[gi])
            );
        end
    endgenerate
    assign info3_s = pins_s[5];
    assign info1_s = pins_s[4];
    assign frame_sync_error_live_s = pins_s[3];
    assign asi_s = pins_s[2:0];

    // previous values for change detection
    logic info3_p_q;
    logic info1_p_q;
    logic frame_sync_error_live_p_q;
    logic [2:0] asi_p_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            info3_p_q <= 1'b0;
            info1_p_q <= 1'b0;
            frame_sync_error_live_p_q <= 1'b0;
            asi_p_q <= 3'h0;
        end else begin
            info3_p_q <= info3_s;
            info1_p_q <= info1_s;
            frame_sync_error_live_p_q <= frame_sync_error_live_s;
            asi_p_q <= asi_s;
        end
    end

    wire act_change = (info3_s != info3_p_q) || (info1_s != info1_p_q)
                      || (asi_s != asi_p_q);
    wire frame_sync_error_live_rise = frame_sync_error_live_s && !frame_sync_error_live_p_q;

    // ahb address phase capture
    logic wr_q;
    logic rd_q;
    logic [7:0] idx_q;
    wire bus_take = hsel && hready && htrans[1];
    wire [7:0] bus_idx = haddr[SIC_AW-1:2];
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= SIC_RST_BYTE;
        end else begin
            wr_q <= bus_take && hwrite;
            rd_q <= bus_take && !hwrite;
            idx_q <= bus_idx;
        end
    end
    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire wr_en = wr_q && idx_q == SIC_IDX_ENABLES;
    wire wr_op = wr_q && idx_q == SIC_IDX_OPCTRL;
    wire wr_b1 = wr_q && idx_q == SIC_IDX_B1_UPSTREAM_OVERRIDE_BYTE;
    wire wr_b1c = wr_q && idx_q == SIC_IDX_B1_CTRL;
    // read of the flag register is decoded in the address phase so data and clear line up
    wire rd_flags = bus_take && !hwrite && bus_idx == SIC_IDX_FLAGS;

    // event flags
    sic_ev_if ev ();
    assign ev.raw_set = {act_change, frame_sync_error_live_rise, q_nibble_done, s_nibbles_sent};
    assign ev.rd_clear = rd_flags;
    sic_flags u_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ev(ev.owner)
    );

    // software registers
    logic [SIC_NFLAGS-1:0] enables_q;
    logic [7:0] opctrl_q;
    logic [7:0] b1_upstream_override_byte_q;
    logic [2:0] b1ctrl_q;
    logic [SIC_NFLAGS-1:0] flags_rd_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enables_q <= '0;
            opctrl_q <= SIC_RST_BYTE;
            b1_upstream_override_byte_q <= SIC_RST_BYTE;
            b1ctrl_q <= 3'h0;
            flags_rd_q <= '0;
        end else begin
            if (wr_en) begin
                enables_q <= hwdata[SIC_NFLAGS-1:0];
            end
            if (wr_op) begin
                // reserved bits are kept at zero whatever is written
                opctrl_q <= hwdata[7:0] & SIC_OP_MASK;
            end
            if (wr_b1) begin
                b1_upstream_override_byte_q <= hwdata[7:0];
            end
            if (wr_b1c) begin
                b1ctrl_q <= hwdata[2:0];
            end
            // snapshot before the clear, including a same-cycle set
            if (rd_flags) begin
                flags_rd_q <= ev.flags | ev.raw_set;
            end
        end
    end

    // read mux
    wire [7:0] s_status_register = {2'h0, frame_sync_error_live_s, info3_s, info1_s, asi_s};
    logic [7:0] rd_byte;
    always_comb begin
        case (idx_q)
            SIC_IDX_FLAGS: rd_byte = {4'h0, flags_rd_q};
            SIC_IDX_ENABLES: rd_byte = {4'h0, enables_q};
            SIC_IDX_OPCTRL: rd_byte = opctrl_q;
            SIC_IDX_B1_UPSTREAM_OVERRIDE_BYTE: rd_byte = b1_upstream_override_byte_q;
            SIC_IDX_S_STATUS: rd_byte = s_status_register;
            SIC_IDX_B1_CTRL: rd_byte = {5'h0, b1ctrl_q};
            default: rd_byte = SIC_RST_BYTE;
        endcase
    end
    assign hrdata = rd_q ? {24'h0, rd_byte} : 32'h0;

    // interrupt request
    assign s_irq = |(ev.flags & enables_q);

    // activation indicator: window from info 1 falling until info 3 rising
    logic sai_win_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sai_win_q <= 1'b0;
        end else if (!info1_s && info1_p_q) begin
            sai_win_q <= 1'b1;
        end else if (info3_s && !info3_p_q) begin
            sai_win_q <= 1'b0;
        end
    end
    assign upstream_activation_indicator = sai_win_q && !opctrl_q[SIC_OP_STRICT];

    assign backswing_suppress_en = !opctrl_q[SIC_OP_BSW];
    assign termination_role_select = opctrl_q[SIC_OP_ROLE];
    // role overrides the port direction register
    assign port2_pin6_oe = port2_dir6 && !opctrl_q[SIC_OP_ROLE];
    assign timing_reference_8khz_sel = opctrl_q[SIC_OP_ROLE];

    wire b1_force = b1ctrl_q[SIC_B1_FORCE] && b1ctrl_q[SIC_B1_OVERRIDE_SELECT] && !b1ctrl_q[SIC_B1_LOOP];
    logic [7:0] b1_out_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            b1_out_q <= SIC_RST_BYTE;
        end else begin
            b1_out_q <= b1_force ? b1_upstream_override_byte_q : b1_upstream_normal;
        end
    end
    assign b1_upstream_out = b1_out_q;

    // steps of the multi-cycle behaviours
    sequence s_frame_sync_error_live_rise;
        !frame_sync_error_live_s ##1 frame_sync_error_live_s;
    endsequence
    sequence s_info1_fall;
        info1_p_q && !info1_s;
    endsequence
    sequence s_info3_rise;
        !info3_p_q && info3_s;
    endsequence
    sequence s_flag_read;
        rd_flags;
    endsequence

    // event flags
    a_frame_sync_error_live_edge_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (frame_sync_error_live_s && frame_sync_error_live_p_q) |-> !ev.raw_set[SIC_BIT_FRAME_SYNC_ERROR_LIVE])
        else $error("frame error flag set without rising edge");
    a_frame_sync_error_live_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_frame_sync_error_live_rise |=> ev.flags[SIC_BIT_FRAME_SYNC_ERROR_LIVE])
        else $error("frame error rise not latched");
    a_act_change: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($changed(asi_s) || $changed(info1_s)) |=> ev.flags[SIC_BIT_ACT])
        else $error("activation change not flagged");
    a_act_info3: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(info3_s) |=> ev.flags[SIC_BIT_ACT])
        else $error("info 3 change not flagged");
    a_q_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        q_nibble_done |=> ev.flags[SIC_BIT_QNIB])
        else $error("q nibble flag missed");
    a_ready_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_nibbles_sent |=> ev.flags[SIC_BIT_SRDY])
        else $error("ready flag missed");
    a_flag_returned: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_flag_read |=> ((hrdata[SIC_NFLAGS-1:0] & $past(ev.flags)) == $past(ev.flags)))
        else $error("set flag not returned by read");

    // status and enables on the bus, and the enable gate on the interrupt
    a_status_live: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rd_q && idx_q == SIC_IDX_S_STATUS) |-> hrdata[SIC_ST_FRAME_SYNC_ERROR_LIVE] == frame_sync_error_live_s)
        else $error("live frame error not readable");
    a_en_reg: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_en |=> enables_q == $past(hwdata[SIC_NFLAGS-1:0]))
        else $error("enable register not written");
    a_en_upper: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (rd_q && idx_q == SIC_IDX_ENABLES) |-> hrdata[7:SIC_NFLAGS] == '0)
        else $error("enable register upper bits not zero");
    a_irq_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (enables_q == '0) |-> !s_irq)
        else $error("irq with all enables off");

    // activation indicator
    a_sai_strict: assert property (@(posedge sys_clk) disable iff (sys_rst)
        opctrl_q[SIC_OP_STRICT] |-> !upstream_activation_indicator)
        else $error("indicator high in strict mode");
    a_strict_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_op && hwdata[SIC_OP_STRICT] |=> !upstream_activation_indicator)
        else $error("strict write left indicator high");
    a_sai_open: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_info1_fall ##1 !opctrl_q[SIC_OP_STRICT] |-> upstream_activation_indicator)
        else $error("indicator not raised on info 1 fall");
    a_sai_close: assert property (@(posedge sys_clk) disable iff (sys_rst)
        s_info3_rise ##0 !(info1_p_q && !info1_s) |=> !upstream_activation_indicator)
        else $error("indicator not dropped on info 3 rise");

    // backswing and role
    a_bsw: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_op |=> backswing_suppress_en == !$past(hwdata[SIC_OP_BSW]))
        else $error("backswing control wrong");
    a_role_pin: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_op && hwdata[SIC_OP_ROLE] |=> !port2_pin6_oe && timing_reference_8khz_sel)
        else $error("pin not forced input in lt role");
    a_role_nt: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_op && !hwdata[SIC_OP_ROLE] |=> !timing_reference_8khz_sel
            && (port2_pin6_oe == port2_dir6))
        else $error("nt role does not follow direction register");

    // b1 upstream path
    a_b1_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_b1 |=> b1_upstream_override_byte_q == $past(hwdata[7:0]))
        else $error("override byte not stored");
    a_b1_force: assert property (@(posedge sys_clk) disable iff (sys_rst)
        b1_force |=> b1_upstream_out == $past(b1_upstream_override_byte_q))
        else $error("override byte not sent");
    a_b1_normal: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !b1_force |=> b1_upstream_out == $past(b1_upstream_normal))
        else $error("normal b1 data not passed");
endmodule // sic_top
`default_nettype wire

// ---- tb/s_iface_irq_and_op_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module s_iface_irq_and_op_control_tb
    import sic_pkg::*;
;
    logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, asf;
    logic info3, info1, fse, qnd, ssent, p2dir, s_irq, ind, bse, role, oe, tsel;
    logic [7:0] b1n, b1o;
    wire logic hready = hreadyout;
    int error_cnt, checked;
    // ordinary register cases: index, write byte, expected read byte
    localparam int NR = 7;
    logic [7:0] r_idx [NR] = '{SIC_IDX_ENABLES, SIC_IDX_ENABLES, SIC_IDX_OPCTRL, SIC_IDX_OPCTRL,
                              SIC_IDX_B1_UPSTREAM_OVERRIDE_BYTE, SIC_IDX_B1_UPSTREAM_OVERRIDE_BYTE, 8'hFF};
    logic [7:0] r_wd [NR] = '{8'h0F, 8'h05, 8'hC8, 8'h40, 8'hA5, 8'h5A, 8'h55};
    logic [7:0] r_ex [NR] = '{8'h0F, 8'h05, 8'hC8, 8'h40, 8'hA5, 8'h5A, 8'h00};

    sic_top u_sic_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_activation_signal_3(info3), .rx_activation_signal_1(info1),
        .activation_state_field(asf), .frame_sync_error_live(fse), .q_nibble_done(qnd),
        .s_nibbles_sent(ssent), .s_irq(s_irq), .upstream_activation_indicator(ind),
        .backswing_suppress_en(bse), .termination_role_select(role), .port2_dir6(p2dir),
        .port2_pin6_oe(oe), .timing_reference_8khz_sel(tsel), .b1_upstream_normal(b1n),
        .b1_upstream_out(b1o));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic cmp_reg(input logic [7:0] e, input logic [31:0] g);
        checked++;
        if (g !== {24'h0, e}) begin
            error_cnt++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // got first, then expected, as the calls give them
    task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (hready === 1'b1) break;
        end
        if (n == 20) begin
            error_cnt++;
            end_sim();
        end
    endtask

    task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= SIC_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic pulse(input logic q);
        if (q) qnd <= 1'b1;
        else ssent <= 1'b1;
        @(posedge sys_clk);
        qnd <= 1'b0;
        ssent <= 1'b0;
        wt(3);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
        xfer(idx, 1'b0, 8'h00);
        cmp_reg(e, rd);
        cmp_pin({6'h0, hreadyout, hresp}, 8'h02);
    endtask

    initial begin
        {hsel, hwrite, info3, info1, fse, qnd, ssent} = '0;
        haddr = '0; hwdata = '0; htrans = '0; hsize = 3'h2; asf = '0;
        p2dir = 1'b1; b1n = 8'h3C; sys_rst = 1'b1;
        wt(4);
        sys_rst <= 1'b0;
        rd_chk(SIC_IDX_FLAGS, 8'h00);
        rd_chk(SIC_IDX_ENABLES, 8'h00);
        rd_chk(SIC_IDX_OPCTRL, 8'h00);
        cmp_pin({4'h0, s_irq, bse, role, tsel}, 8'h04);
        cmp_pin({7'h0, oe}, 8'h01);
        for (int i = 0; i < NR; i++) begin
            xfer(r_idx[i], 1'b1, r_wd[i]);
            rd_chk(r_idx[i], r_ex[i]);
        end
        // flags, enables and request
        xfer(SIC_IDX_ENABLES, 1'b1, 8'h0F);
        pulse(1'b0);
        cmp_pin({7'h0, s_irq}, 8'h01);
        rd_chk(SIC_IDX_FLAGS, 8'h01);
        rd_chk(SIC_IDX_FLAGS, 8'h00);
        cmp_pin({7'h0, s_irq}, 8'h00);
        xfer(SIC_IDX_ENABLES, 1'b1, 8'h00);
        pulse(1'b1);
        cmp_pin({7'h0, s_irq}, 8'h00);
        rd_chk(SIC_IDX_FLAGS, 8'h02);
        // activation change from each source
        asf <= 3'h5;
        wt(8);
        rd_chk(SIC_IDX_FLAGS, 8'h08);
        info1 <= 1'b1;
        wt(8);
        rd_chk(SIC_IDX_FLAGS, 8'h08);
        info3 <= 1'b1;
        wt(8);
        rd_chk(SIC_IDX_FLAGS, 8'h08);
        // indicator window, then strict mode
        xfer(SIC_IDX_OPCTRL, 1'b1, 8'h00);
        info3 <= 1'b0;
        wt(8);
        info1 <= 1'b0;
        wt(8);
        cmp_pin({7'h0, ind}, 8'h01);
        info3 <= 1'b1;
        wt(8);
        cmp_pin({7'h0, ind}, 8'h00);
        xfer(SIC_IDX_OPCTRL, 1'b1, 8'h80);
        info3 <= 1'b0;
        info1 <= 1'b1;
        wt(8);
        info1 <= 1'b0;
        wt(8);
        cmp_pin({7'h0, ind}, 8'h00);
        // frame error: edge only, live level readable
        xfer(SIC_IDX_FLAGS, 1'b0, 8'h00);
        fse <= 1'b1;
        wt(8);
        rd_chk(SIC_IDX_FLAGS, 8'h04);
        rd_chk(SIC_IDX_S_STATUS, 8'h25);
        cmp_pin({7'h0, rd[SIC_ST_FRAME_SYNC_ERROR_LIVE]}, 8'h01);
        wt(8);
        rd_chk(SIC_IDX_FLAGS, 8'h00);
        fse <= 1'b0;
        wt(8);
        rd_chk(SIC_IDX_S_STATUS, 8'h05);
        cmp_pin({7'h0, rd[SIC_ST_FRAME_SYNC_ERROR_LIVE]}, 8'h00);
        rd_chk(SIC_IDX_FLAGS, 8'h00);
        fse <= 1'b1;
        wt(8);
        rd_chk(SIC_IDX_FLAGS, 8'h04);
        // role and backswing pins
        xfer(SIC_IDX_OPCTRL, 1'b1, 8'hC8);
        wt(1);
        cmp_pin({4'h0, oe, bse, role, tsel}, 8'h03);
        xfer(SIC_IDX_OPCTRL, 1'b1, 8'h00);
        wt(1);
        cmp_pin({4'h0, oe, bse, role, tsel}, 8'h0C);
        p2dir <= 1'b0;
        wt(1);
        cmp_pin({7'h0, oe}, 8'h00);
        // b1 override only with force, select and no loopback
        xfer(SIC_IDX_B1_UPSTREAM_OVERRIDE_BYTE, 1'b1, 8'hA5);
        xfer(SIC_IDX_B1_CTRL, 1'b1, 8'h03);
        wt(2);
        cmp_pin(b1o, 8'hA5);
        xfer(SIC_IDX_B1_CTRL, 1'b1, 8'h07);
        wt(2);
        cmp_pin(b1o, 8'h3C);
        xfer(SIC_IDX_B1_CTRL, 1'b1, 8'h01);
        wt(2);
        cmp_pin(b1o, 8'h3C);
        // second reset in mid-run
        xfer(SIC_IDX_ENABLES, 1'b1, 8'h0F);
        xfer(SIC_IDX_OPCTRL, 1'b1, 8'hC8);
        rd_chk(SIC_IDX_ENABLES, 8'h0F);
        sys_rst <= 1'b1;
        wt(2);
        sys_rst <= 1'b0;
        rd_chk(SIC_IDX_ENABLES, 8'h00);
        rd_chk(SIC_IDX_OPCTRL, 8'h00);
        cmp_pin({4'h0, s_irq, bse, role, tsel}, 8'h04);
        end_sim();
    end
endmodule // s_iface_irq_and_op_control_tb
`default_nettype wire
